// >>> rtl/gdi_device.sv
`timescale 1ns/10ps
module gdi_device #(
    parameter bit EXTENDED = 1'b0
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    // Configuration from the instrument
    input wire logic [gdi_pkg::GDI_ADDR_W-1:0] my_addr_i,
    input wire logic [gdi_pkg::GDI_ADDR_W-1:0] my_sec_i,
    input wire logic [2:0] ppoll_line_i,
    input wire logic ppoll_sense_i,
    // Bus lines, active low, each open drain
    input wire logic [7:0] dio_n_i,
    output logic [7:0] dio_n_o,
    output logic [7:0] dio_oe_n_o,
    input wire logic dav_n_i,
    output logic dav_n_o,
    output logic dav_oe_n_o,
    input wire logic nrfd_n_i,
    output logic nrfd_n_o,
    output logic nrfd_oe_n_o,
    input wire logic ndac_n_i,
    output logic ndac_n_o,
    output logic ndac_oe_n_o,
    input wire logic eoi_n_i,
    output logic eoi_n_o,
    output logic eoi_oe_n_o,
    input wire logic atn_n_i,
    input wire logic ifc_n_i,
    input wire logic ren_n_i,
    output logic srq_n_o,
    output logic srq_oe_n_o,
    // Instrument side
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    output logic rx_end_o,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_end_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic [7:0] status_i,
    input wire logic rsv_i,
    output logic listen_o,
    output logic talk_o,
    output logic remote_o,
    output logic lockout_o,
    output logic spoll_o,
    output logic clear_o,
    output logic trigger_o,
    output logic take_ctrl_o
);
    import gdi_pkg::*;

    // Two-stage synchronisers; only the second stage is used
    localparam int NL = 13;
    logic [NL-1:0] sync1_reg;
    logic [NL-1:0] sync2_reg;
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            sync1_reg <= '1;
            sync2_reg <= '1;
        end else begin
            sync1_reg <= {dio_n_i, dav_n_i, nrfd_n_i, ndac_n_i, eoi_n_i, atn_n_i};
            sync2_reg <= sync1_reg;
        end
    end
    // Interface clear and remote enable get their own chain below
    logic ifc_s1_reg, ifc_s2_reg, ren_s1_reg, ren_s2_reg;
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ifc_s1_reg <= 1'b1;
            ifc_s2_reg <= 1'b1;
            ren_s1_reg <= 1'b1;
            ren_s2_reg <= 1'b1;
        end else begin
            ifc_s1_reg <= ifc_n_i;
            ifc_s2_reg <= ifc_s1_reg;
            ren_s1_reg <= ren_n_i;
            ren_s2_reg <= ren_s1_reg;
        end
    end

    logic [7:0] dio;
    logic dav, nrfd, ndac, eoi, atn, ifc, ren;
    assign dio = ~sync2_reg[12:5];
    assign dav = ~sync2_reg[4];
    assign nrfd = ~sync2_reg[3];
    assign ndac = ~sync2_reg[2];
    assign eoi = ~sync2_reg[1];
    assign atn = ~sync2_reg[0];
    assign ifc = ~ifc_s2_reg;
    assign ren = ~ren_s2_reg;

    // Parallel poll; attention with end-or-identify
    logic ppoll;
    assign ppoll = atn & eoi;

    // Acceptor handshake
    gdi_ah_state_t ah_reg;
    logic listen_reg, talk_reg, lpend_reg, tpend_reg;
    logic accept;
    always_ff @(posedge clk_i) begin
        if (!nrst_i || ifc) begin
            ah_reg <= GDI_AH_READY;
        end else begin
            unique case (ah_reg)
                GDI_AH_READY: begin
                    if (dav && !ppoll && (atn || listen_reg)) begin
                        ah_reg <= GDI_AH_TAKE;
                    end
                end
                GDI_AH_TAKE: begin
                    ah_reg <= GDI_AH_DONE;
                end
                GDI_AH_DONE: begin
                    if (!dav) begin
                        ah_reg <= GDI_AH_READY;
                    end
                end
            endcase
        end
    end
    assign accept = (ah_reg == GDI_AH_TAKE);

    // Command decode
    function automatic logic is_cmd(input logic [7:0] b, input logic [6:0] c);
        return b[6:0] == c;
    endfunction : is_cmd

    logic cmd_byte, data_byte;
    assign cmd_byte = accept & atn;
    assign data_byte = accept & ~atn & listen_reg;

    logic addr_lis, addr_tlk, other_tlk, sec_byte;
    assign addr_lis = cmd_byte && dio[6:5] == GDI_GRP_LISTEN && dio[4:0] == my_addr_i;
    assign addr_tlk = cmd_byte && dio[6:5] == GDI_GRP_TALK && dio[4:0] == my_addr_i;
    assign other_tlk = cmd_byte && dio[6:5] == GDI_GRP_TALK && dio[4:0] != my_addr_i
        && !is_cmd(dio, GDI_CMD_UNT);
    assign sec_byte = cmd_byte && dio[6:5] == GDI_GRP_SECOND;

    // Addressed states
    always_ff @(posedge clk_i) begin
        if (!nrst_i || ifc) begin
            listen_reg <= 1'b0;
            talk_reg <= 1'b0;
            lpend_reg <= 1'b0;
            tpend_reg <= 1'b0;
        end else if (cmd_byte) begin
            lpend_reg <= EXTENDED && addr_lis;
            tpend_reg <= EXTENDED && addr_tlk;
            if (is_cmd(dio, GDI_CMD_UNL)) begin
                listen_reg <= 1'b0;
            end else if (addr_lis && !EXTENDED) begin
                listen_reg <= 1'b1;
            end else if (sec_byte && lpend_reg && dio[4:0] == my_sec_i) begin
                listen_reg <= 1'b1;
            end
            if (is_cmd(dio, GDI_CMD_UNT) || other_tlk) begin
                talk_reg <= 1'b0;
            end else if (addr_tlk && !EXTENDED) begin
                talk_reg <= 1'b1;
            end else if (sec_byte && tpend_reg && dio[4:0] == my_sec_i) begin
                talk_reg <= 1'b1;
            end
        end
    end

    // Remote, lockout, serial poll and event pulses
    logic remote_reg, lockout_reg, spoll_reg;
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            remote_reg <= 1'b0;
            lockout_reg <= 1'b0;
            spoll_reg <= 1'b0;
            clear_o <= 1'b0;
            trigger_o <= 1'b0;
            take_ctrl_o <= 1'b0;
        end else begin
            clear_o <= cmd_byte && (is_cmd(dio, GDI_CMD_DCL)
                || (is_cmd(dio, GDI_CMD_SDC) && (listen_reg || talk_reg)));
            trigger_o <= cmd_byte && is_cmd(dio, GDI_CMD_GET) && listen_reg;
            take_ctrl_o <= cmd_byte && is_cmd(dio, GDI_CMD_TCT) && talk_reg;
            if (!ren) begin
                remote_reg <= 1'b0;
                lockout_reg <= 1'b0;
            end else begin
                if (cmd_byte && is_cmd(dio, GDI_CMD_GTL) && listen_reg) begin
                    remote_reg <= 1'b0;
                end else if (addr_lis) begin
                    remote_reg <= 1'b1;
                end
                if (cmd_byte && is_cmd(dio, GDI_CMD_LLO)) begin
                    lockout_reg <= 1'b1;
                end
            end
            if (ifc) begin
                spoll_reg <= 1'b0;
            end else if (cmd_byte && is_cmd(dio, GDI_CMD_SPE)) begin
                spoll_reg <= 1'b1;
            end else if (cmd_byte && is_cmd(dio, GDI_CMD_SPD)) begin
                spoll_reg <= 1'b0;
            end
        end
    end

    // Received data to the instrument
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rx_data_o <= 8'h00;
            rx_valid_o <= 1'b0;
            rx_end_o <= 1'b0;
        end else begin
            rx_valid_o <= data_byte;
            if (data_byte) begin
                rx_data_o <= dio;
                rx_end_o <= eoi;
            end
        end
    end

    // Source handshake; bytes wait in one holding register
    gdi_sh_state_t sh_reg;
    logic [7:0] tx_reg;
    logic tx_end_reg;
    always_ff @(posedge clk_i) begin
        if (!nrst_i || ifc || !talk_reg || atn) begin
            sh_reg <= GDI_SH_IDLE;
            tx_reg <= 8'h00;
            tx_end_reg <= 1'b0;
        end else begin
            unique case (sh_reg)
                GDI_SH_IDLE: begin
                    if (spoll_reg) begin
                        tx_reg <= {rsv_i, status_i[6:0]};
                        tx_end_reg <= 1'b0;
                        sh_reg <= GDI_SH_WAIT_RDY;
                    end else if (tx_valid_i && tx_ready_o) begin
                        tx_reg <= tx_data_i;
                        tx_end_reg <= tx_end_i;
                        sh_reg <= GDI_SH_WAIT_RDY;
                    end
                end
                GDI_SH_WAIT_RDY: begin
                    if (!nrfd) begin
                        sh_reg <= GDI_SH_VALID;
                    end
                end
                GDI_SH_VALID: begin
                    if (!ndac) begin
                        sh_reg <= GDI_SH_RELEASE;
                    end
                end
                GDI_SH_RELEASE: begin
                    sh_reg <= GDI_SH_IDLE;
                end
            endcase
        end
    end

    // Service request from the instrument
    logic srq_reg;
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            srq_reg <= 1'b0;
        end else begin
            srq_reg <= rsv_i;
        end
    end

    // Pin drivers, all registered; enable low while driving
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            dio_n_o <= 8'hFF;
            dio_oe_n_o <= 8'hFF;
            dav_n_o <= 1'b1;
            dav_oe_n_o <= 1'b1;
            nrfd_n_o <= 1'b1;
            nrfd_oe_n_o <= 1'b1;
            ndac_n_o <= 1'b1;
            ndac_oe_n_o <= 1'b1;
            eoi_n_o <= 1'b1;
            eoi_oe_n_o <= 1'b1;
            srq_n_o <= 1'b1;
            srq_oe_n_o <= 1'b1;
        end else begin
            if (ppoll && !ifc) begin
                dio_n_o <= 8'h00;
                dio_oe_n_o <= ~((8'h01 << ppoll_line_i) & {8{rsv_i ~^ ppoll_sense_i}});
                eoi_oe_n_o <= 1'b1;
            end else if (sh_reg == GDI_SH_WAIT_RDY || sh_reg == GDI_SH_VALID) begin
                dio_n_o <= ~tx_reg;
                dio_oe_n_o <= ~tx_reg;
                eoi_n_o <= 1'b0;
                eoi_oe_n_o <= ~tx_end_reg;
            end else begin
                dio_n_o <= 8'hFF;
                dio_oe_n_o <= 8'hFF;
                eoi_oe_n_o <= 1'b1;
            end
            dav_n_o <= 1'b0;
            dav_oe_n_o <= ~(sh_reg == GDI_SH_VALID);
            nrfd_n_o <= 1'b0;
            nrfd_oe_n_o <= ~(ah_reg != GDI_AH_READY && !ifc);
            ndac_n_o <= 1'b0;
            ndac_oe_n_o <= ~((atn || listen_reg) && ah_reg != GDI_AH_DONE && !ifc);
            srq_n_o <= 1'b0;
            srq_oe_n_o <= ~srq_reg;
        end
    end

    // Status to the instrument
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            listen_o <= 1'b0;
            talk_o <= 1'b0;
            remote_o <= 1'b0;
            lockout_o <= 1'b0;
            spoll_o <= 1'b0;
            tx_ready_o <= 1'b0;
        end else begin
            listen_o <= listen_reg;
            talk_o <= talk_reg;
            remote_o <= remote_reg;
            lockout_o <= lockout_reg;
            spoll_o <= spoll_reg;
            tx_ready_o <= talk_reg && !atn && !spoll_reg && sh_reg == GDI_SH_IDLE;
        end
    end
endmodule : gdi_device

// >>> rtl/gdi_pkg.sv
package gdi_pkg;
    // Bus command codes on the low seven data lines
    localparam logic [6:0] GDI_CMD_GTL = 7'h01;
    localparam logic [6:0] GDI_CMD_SDC = 7'h04;
    localparam logic [6:0] GDI_CMD_GET = 7'h08;
    localparam logic [6:0] GDI_CMD_TCT = 7'h09;
    localparam logic [6:0] GDI_CMD_LLO = 7'h11;
    localparam logic [6:0] GDI_CMD_DCL = 7'h14;
    localparam logic [6:0] GDI_CMD_SPE = 7'h18;
    localparam logic [6:0] GDI_CMD_SPD = 7'h19;
    localparam logic [6:0] GDI_CMD_UNL = 7'h3F;
    localparam logic [6:0] GDI_CMD_UNT = 7'h5F;
    // Address groups, upper two bits of the seven-bit code
    localparam logic [1:0] GDI_GRP_LISTEN = 2'h1;
    localparam logic [1:0] GDI_GRP_TALK = 2'h2;
    localparam logic [1:0] GDI_GRP_SECOND = 2'h3;
    localparam int GDI_ADDR_W = 5;
    localparam int GDI_SYNC_STAGES = 2;

    // Acceptor handshake states, Gray along the path except the return from done to ready
    typedef enum logic [1:0] {
        GDI_AH_READY = 2'b00,
        GDI_AH_TAKE = 2'b01,
        GDI_AH_DONE = 2'b11
    } gdi_ah_state_t;

    // Source handshake states, Gray along the path
    typedef enum logic [1:0] {
        GDI_SH_IDLE = 2'b00,
        GDI_SH_WAIT_RDY = 2'b01,
        GDI_SH_VALID = 2'b11,
        GDI_SH_RELEASE = 2'b10
    } gdi_sh_state_t;
endpackage : gdi_pkg

// >>> verification/gdi_device_sva.sv
`timescale 1ns/10ps
module gdi_device_chk (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [2:0] ppoll_line_i,
    input wire logic ppoll_sense_i,
    input wire logic nrfd_n_i,
    input wire logic eoi_n_i,
    input wire logic atn_n_i,
    input wire logic ifc_n_i,
    input wire logic ren_n_i,
    input wire logic rsv_i,
    input wire logic [7:0] dio_oe_n_o,
    input wire logic dav_oe_n_o,
    input wire logic ndac_oe_n_o,
    input wire logic eoi_oe_n_o,
    input wire logic srq_oe_n_o,
    input wire logic rx_valid_o,
    input wire logic listen_o,
    input wire logic talk_o,
    input wire logic remote_o,
    input wire logic lockout_o,
    input wire logic trigger_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // Five cycles covers the two sync stages, the state and the output register
    sequence s_ifc_held;
        (!ifc_n_i)[*5];
    endsequence
    sequence s_ppoll_req;
        (!atn_n_i && !eoi_n_i && rsv_i == ppoll_sense_i)[*4];
    endsequence
    property p_ifc;
        s_ifc_held |-> !listen_o && !talk_o && dav_oe_n_o;
    endproperty
    property p_ppoll;
        s_ppoll_req |-> !dio_oe_n_o[ppoll_line_i];
    endproperty
    property p_src_wait;
        $fell(dav_oe_n_o) |-> $past(nrfd_n_i, 4);
    endproperty
    property p_stable;
        !dav_oe_n_o && $past(!dav_oe_n_o) |-> $stable(dio_oe_n_o) && $stable(eoi_oe_n_o);
    endproperty
    property p_accept;
        rx_valid_o |-> ##[0:2] ndac_oe_n_o;
    endproperty
    property p_srq;
        ($stable(rsv_i))[*3] |-> srq_oe_n_o == !rsv_i;
    endproperty
    property p_remote;
        (ren_n_i)[*5] |-> !remote_o && !lockout_o;
    endproperty
    property p_dav_talker;
        !dav_oe_n_o |-> talk_o || $past(talk_o);
    endproperty
    property p_trig_pulse;
        trigger_o |=> !trigger_o;
    endproperty
    a_ifc: assert property (p_ifc) else $error("ifc did not clear roles");
    a_ppoll: assert property (p_ppoll) else $error("poll line not driven");
    a_src_wait: assert property (p_src_wait) else $error("dav before ready");
    a_stable: assert property (p_stable) else $error("data moved under dav");
    a_accept: assert property (p_accept) else $error("ndac not released");
    a_srq: assert property (p_srq) else $error("srq does not follow request");
    a_remote: assert property (p_remote) else $error("remote without enable");
    a_dav_talker: assert property (p_dav_talker) else $error("dav when not talker");
    a_trig_pulse: assert property (p_trig_pulse) else $error("trigger too long");
endmodule : gdi_device_chk

bind gdi_device gdi_device_chk u_chk (.clk_i, .nrst_i, .ppoll_line_i, .ppoll_sense_i,
    .nrfd_n_i, .eoi_n_i, .atn_n_i, .ifc_n_i, .ren_n_i, .rsv_i, .dio_oe_n_o, .dav_oe_n_o,
    .ndac_oe_n_o, .eoi_oe_n_o, .srq_oe_n_o, .rx_valid_o, .listen_o, .talk_o, .remote_o,
    .lockout_o, .trigger_o);

// >>> verification/gdi_ctrl_model.sv
`timescale 1ns/10ps
module gdi_ctrl_model (
    input wire logic clk_i,
    input wire logic [7:0] dio_i,
    input wire logic dav_i,
    input wire logic nrfd_i,
    input wire logic ndac_i,
    input wire logic eoi_i,
    output logic [7:0] dio_o = 8'hFF,
    output logic dav_o = 1'b1,
    output logic nrfd_o = 1'b1,
    output logic ndac_o = 1'b1,
    output logic eoi_o = 1'b1,
    output logic atn_o = 1'b1,
    output logic ifc_o = 1'b1,
    output logic ren_o = 1'b1
);
    // Sole system controller: ifc and ren only driven here
    task automatic lines(input logic a, input logic e, input logic f, input logic r);
        atn_o <= a;
        eoi_o <= e;
        ifc_o <= f;
        ren_o <= r;
        @(posedge clk_i);
    endtask : lines
    task automatic hold();
        nrfd_o <= 1'b0;
        ndac_o <= 1'b0;
        @(posedge clk_i);
    endtask : hold
    // Bounded waits: a silent device must not hang the run
    task automatic src(input logic [7:0] b, input logic a, input logic e);
        int n;
        // As source the controller lets go of its own acceptor lines
        nrfd_o <= 1'b1;
        ndac_o <= 1'b1;
        n = 0;
        while ((!nrfd_i || ndac_i) && n < 60) begin
            @(posedge clk_i);
            n++;
        end
        dio_o <= ~b;
        eoi_o <= ~e;
        atn_o <= ~a;
        @(posedge clk_i);
        dav_o <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (!ndac_i && n < 60);
        dav_o <= 1'b1;
        dio_o <= 8'hFF;
        eoi_o <= 1'b1;
        @(posedge clk_i);
    endtask : src
    task automatic rd(output logic [7:0] b, output logic e);
        int n;
        nrfd_o <= 1'b1;
        ndac_o <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (dav_i && n < 60);
        b = ~dio_i;
        e = !eoi_i;
        nrfd_o <= 1'b0;
        ndac_o <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (!dav_i && n < 60);
        // Stay not ready so a repeating source waits for the next read
        ndac_o <= 1'b0;
    endtask : rd
endmodule : gdi_ctrl_model

// >>> verification/tb_gdi_device_interface.sv
`timescale 1ns/10ps
module tb_gdi_device_interface;
    import gdi_pkg::*;
    localparam logic [4:0] ADDR = 5'h0A;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic rsv_i = 1'b0;
    logic tx_valid_i = 1'b0;
    logic tx_end_i = 1'b0;
    logic [7:0] tx_data_i = 8'h00;
    logic [7:0] dio_n_o, dio_oe_n_o, rx_data_o, dio_c, rb;
    logic dav_n_o, dav_oe_n_o, nrfd_n_o, nrfd_oe_n_o, ndac_n_o, ndac_oe_n_o, eoi_n_o;
    logic eoi_oe_n_o, srq_n_o, srq_oe_n_o, rx_valid_o, rx_end_o, tx_ready_o, re;
    logic listen_o, talk_o, remote_o, lockout_o, spoll_o, clear_o, trigger_o, take_ctrl_o;
    logic dav_c, nrfd_c, ndac_c, eoi_c, atn_c, ifc_c, ren_c;
    logic [8:0] rx_last = 9'h000;
    int miscompares = 0, total_checks = 0, n_trig = 0, n_clr = 0, n_take = 0;
    // Open-drain resolution: any party pulling low wins
    wire [7:0] dio_b = dio_c & (dio_oe_n_o | dio_n_o);
    wire dav_b = dav_c & (dav_oe_n_o | dav_n_o);
    wire nrfd_b = nrfd_c & (nrfd_oe_n_o | nrfd_n_o);
    wire ndac_b = ndac_c & (ndac_oe_n_o | ndac_n_o);
    wire eoi_b = eoi_c & (eoi_oe_n_o | eoi_n_o);
    wire srq_b = srq_oe_n_o | srq_n_o;

    gdi_device #(.EXTENDED(1'b0)) uut (.clk_i, .nrst_i, .my_addr_i(ADDR), .my_sec_i(5'h00),
        .ppoll_line_i(3'd5), .ppoll_sense_i(1'b1), .dio_n_i(dio_b), .dio_n_o, .dio_oe_n_o,
        .dav_n_i(dav_b), .dav_n_o, .dav_oe_n_o, .nrfd_n_i(nrfd_b), .nrfd_n_o, .nrfd_oe_n_o,
        .ndac_n_i(ndac_b), .ndac_n_o, .ndac_oe_n_o, .eoi_n_i(eoi_b), .eoi_n_o, .eoi_oe_n_o,
        .atn_n_i(atn_c), .ifc_n_i(ifc_c), .ren_n_i(ren_c), .srq_n_o, .srq_oe_n_o, .rx_data_o,
        .rx_valid_o, .rx_end_o, .tx_data_i, .tx_end_i, .tx_valid_i, .tx_ready_o,
        .status_i(8'h35), .rsv_i, .listen_o, .talk_o, .remote_o, .lockout_o, .spoll_o,
        .clear_o, .trigger_o, .take_ctrl_o);
    gdi_ctrl_model ctl (.clk_i, .dio_i(dio_b), .dav_i(dav_b), .nrfd_i(nrfd_b), .ndac_i(ndac_b),
        .eoi_i(eoi_b), .dio_o(dio_c), .dav_o(dav_c), .nrfd_o(nrfd_c), .ndac_o(ndac_c),
        .eoi_o(eoi_c), .atn_o(atn_c), .ifc_o(ifc_c), .ren_o(ren_c));

    initial begin
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (trigger_o === 1'b1) n_trig <= n_trig + 1;
        if (clear_o === 1'b1) n_clr <= n_clr + 1;
        if (take_ctrl_o === 1'b1) n_take <= n_take + 1;
        if (rx_valid_o === 1'b1) rx_last <= {rx_end_o, rx_data_o};
    end
    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic cmd(input logic [6:0] c);
        ctl.src({1'b0, c}, 1'b1, 1'b0);
        repeat (4) @(posedge clk_i);
    endtask : cmd
    task automatic t_listen();
        ctl.lines(1'b0, 1'b1, 1'b1, 1'b0);
        cmd({GDI_GRP_LISTEN, ADDR});
        chk(9'(listen_o), 9'h001);
        chk(9'(remote_o), 9'h001);
        ctl.src(8'h5A, 1'b0, 1'b0);
        chk(rx_last, 9'h05A);
        ctl.src(8'hC3, 1'b0, 1'b1);
        chk(rx_last, 9'h1C3);
        $display("test listen done");
    endtask : t_listen
    task automatic t_cmds();
        cmd(GDI_CMD_GET);
        chk(9'(n_trig), 9'h001);
        cmd(7'h05);
        chk({listen_o, remote_o, 7'(n_clr + n_trig)}, 9'h181);
        cmd(GDI_CMD_LLO);
        chk(9'(lockout_o), 9'h001);
        cmd(GDI_CMD_GTL);
        chk(9'(remote_o), 9'h000);
        cmd(GDI_CMD_SDC);
        chk(9'(n_clr), 9'h001);
        cmd(GDI_CMD_UNL);
        chk(9'(listen_o), 9'h000);
        cmd(GDI_CMD_GET);
        chk(9'(n_trig), 9'h001);
        cmd(GDI_CMD_SDC);
        chk(9'(n_clr), 9'h001);
        cmd(GDI_CMD_DCL);
        chk(9'(n_clr), 9'h002);
        ctl.lines(1'b0, 1'b1, 1'b1, 1'b1);
        repeat (6) @(posedge clk_i);
        chk(9'(lockout_o), 9'h000);
        $display("test commands done");
    endtask : t_cmds
    task automatic t_talk();
        cmd({GDI_GRP_TALK, ADDR});
        chk(9'(talk_o), 9'h001);
        cmd(GDI_CMD_SPE);
        chk(9'(spoll_o), 9'h001);
        rsv_i <= 1'b1;
        ctl.lines(1'b1, 1'b1, 1'b1, 1'b1);
        ctl.hold();
        ctl.rd(rb, re);
        chk(9'(rb), 9'h0B5);
        chk(9'(srq_b), 9'h000);
        ctl.lines(1'b0, 1'b1, 1'b1, 1'b1);
        cmd(GDI_CMD_SPD);
        chk(9'(spoll_o), 9'h000);
        ctl.lines(1'b1, 1'b1, 1'b1, 1'b1);
        ctl.hold();
        tx_data_i <= 8'h96;
        tx_end_i <= 1'b1;
        tx_valid_i <= 1'b1;
        // Offer and accept run together; the source may wait on either
        fork
            begin
                for (int n = 0; n < 200 && tx_ready_o !== 1'b1; n++) @(posedge clk_i);
                tx_valid_i <= 1'b0;
            end
            ctl.rd(rb, re);
        join
        chk({re, rb}, 9'h196);
        ctl.lines(1'b0, 1'b1, 1'b1, 1'b1);
        cmd({GDI_GRP_TALK, ADDR + 5'h01});
        chk(9'(talk_o), 9'h000);
        cmd({GDI_GRP_TALK, ADDR});
        cmd(GDI_CMD_TCT);
        chk(9'(n_take), 9'h001);
        $display("test talk done");
    endtask : t_talk
    task automatic t_abort();
        ctl.lines(1'b0, 1'b0, 1'b1, 1'b1);
        repeat (6) @(posedge clk_i);
        chk(9'(dio_b[5]), 9'h000);
        cmd({GDI_GRP_LISTEN, ADDR});
        ctl.lines(1'b0, 1'b1, 1'b0, 1'b1);
        repeat (6) @(posedge clk_i);
        chk({7'h00, listen_o, talk_o}, 9'h000);
        ctl.lines(1'b0, 1'b1, 1'b1, 1'b1);
        $display("test abort done");
    endtask : t_abort
    task automatic end_sim();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        t_listen();
        t_cmds();
        t_talk();
        t_abort();
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        end_sim();
    end
endmodule : tb_gdi_device_interface
